//--- phy_management_register_bank_test.sv
// self-checking bench for the management register bank
// assumes the model and the bound checker are compiled first
module phy_management_register_bank_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] tgt = 5'h0b;
	logic [2:0] mode_pins = 3'b101;
	logic link_up = 1'b1;
	logic remote_fault = 1'b0;
	logic jabber = 1'b0;
	logic aneg_complete = 1'b0;
	logic [7:1] ev = 7'h00;
	logic mclk, m_bit, m_oe, d_out, d_oe, din;
	logic rs, bce, sd;
	logic rs_seen = 1'b0;
	logic oe_seen = 1'b0;
	logic seen_clr = 1'b0;
	logic spd, dup, an, pd, iso, lb, ct, sra, irq_n;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	wire [6:0] cfg = {spd, dup, an, pd, iso, lb, ct};
	// line pulled up when nobody drives
	assign din = d_oe ? d_out : (m_oe ? m_bit : 1'b1);
	pmr_mgmt_model mgmt_i (.sys_clk(sys_clk), .wire_in(din), .mgmt_clk(mclk),
		.drv_bit(m_bit), .drv_oe(m_oe));
	pmr_bank pmr_bank_i (.sys_clk(sys_clk), .rst_n(rst_n), .mgmt_clk(mclk),
		.mgmt_data_in(din), .mgmt_data_out(d_out), .mgmt_data_oe(d_oe),
		.phy_address(5'h0b), .mode_pins(mode_pins), .link_up(link_up),
		.remote_fault(remote_fault), .jabber(jabber), .aneg_complete(aneg_complete),
		.speed_indication(3'b110), .event_pulses(ev), .cfg_speed_100(spd),
		.cfg_full_duplex(dup), .cfg_aneg_enable(an), .aneg_restart(rs), .power_down(pd),
		.isolate(iso), .loopback(lb), .collision_test(ct), .block_coding_enable(bce),
		.scramble_disable(sd), .soft_reset_active(sra), .irq_n(irq_n));
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		rs_seen <= !seen_clr && (rs_seen || rs === 1'b1);
		oe_seen <= !seen_clr && (oe_seen || d_oe === 1'b1);
		if (cyc == 30000) begin
			err_count++;
			final_report();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] rg, input logic [15:0] d);
		logic [15:0] q;
		mgmt_i.frame(1'b0, tgt, rg, d, q);
		repeat (6) @(posedge sys_clk);
	endtask : wr
	task automatic rd(input logic [4:0] rg, input logic [15:0] exp);
		logic [15:0] q;
		mgmt_i.frame(1'b1, tgt, rg, 16'h0000, q);
		repeat (6) @(posedge sys_clk);
		chk(q, exp);
	endtask : rd
	task automatic t_reset;
		chk({9'h0, cfg}, 16'h0050);
		rd(5'h00, 16'h3000);
		rd(5'h01, 16'h7809);
		rd(5'h01, 16'h780d);
		rd(5'h1c, 16'h0000);
		rd(5'h02, 16'h0000);
		rd(5'h1f, 16'h0058);
		chk({14'h0, bce, sd}, 16'h0002);
	endtask : t_reset
	task automatic t_control;
		seen_clr <= 1'b1;
		@(posedge sys_clk);
		seen_clr <= 1'b0;
		wr(5'h00, 16'h4e80);
		chk({9'h0, cfg}, 16'h000f);
		chk({15'h0, rs_seen}, 16'h0001);
		rd(5'h00, 16'h4c80);
		wr(5'h00, 16'h2100);
		chk({9'h0, cfg}, 16'h0060);
		wr(5'h00, 16'h3d80);
		chk({9'h0, cfg}, 16'h007d);
	endtask : t_control
	task automatic t_soft;
		wr(5'h00, 16'h8000);
		chk({15'h0, sra}, 16'h0001);
		repeat (30) @(posedge sys_clk);
		chk({9'h0, cfg}, 16'h0070);
		rd(5'h00, 16'h3100);
	endtask : t_soft
	task automatic t_addr;
		tgt <= 5'h0a;
		seen_clr <= 1'b1;
		@(posedge sys_clk);
		seen_clr <= 1'b0;
		wr(5'h00, 16'h0800);
		rd(5'h00, 16'hffff);
		chk({9'h0, cfg}, 16'h0070);
		chk({15'h0, oe_seen}, 16'h0000);
		tgt <= 5'h0b;
		@(posedge sys_clk);
	endtask : t_addr
	task automatic t_latch;
		{remote_fault, jabber, link_up, aneg_complete} <= 4'b1101;
		repeat (6) @(posedge sys_clk);
		{remote_fault, jabber, link_up} <= 3'b001;
		repeat (6) @(posedge sys_clk);
		rd(5'h01, 16'h783b);
		rd(5'h01, 16'h782d);
		rd(5'h1f, 16'h1058);
		wr(5'h1f, 16'h0001);
		chk({14'h0, bce, sd}, 16'h0001);
		rd(5'h1f, 16'h1019);
	endtask : t_latch
	task automatic t_events;
		wr(5'h1e, 16'hffff);
		rd(5'h1e, 16'h00fe);
		for (int i = 1; i <= 7; i++) begin
			ev <= 7'(16'h1 << (i - 1));
			@(posedge sys_clk);
			ev <= 7'h00;
			// long quiet spell so the checker sees a pending request held
			repeat (50) @(posedge sys_clk);
			chk({15'h0, irq_n}, 16'h0000);
			rd(5'h1d, 16'h1 << i);
			chk({15'h0, irq_n}, 16'h0001);
		end
		wr(5'h1e, 16'h0004);
		ev <= 7'h01;
		@(posedge sys_clk);
		ev <= 7'h00;
		repeat (6) @(posedge sys_clk);
		chk({15'h0, irq_n}, 16'h0001);
		rd(5'h1d, 16'h0002);
	endtask : t_events
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
		t_reset();
		t_control();
		t_soft();
		t_addr();
		t_latch();
		t_events();
		final_report();
	end
endmodule : phy_management_register_bank_test

//--- pmr_bank.sv
// management register bank of a 10/100 transceiver on the serial management port
// assumes the management clock is slow against sys_clk; media status arrives on sys_clk
`include "pmr_consts.svh"

// Functional notes
// - decode registers 0-6, 16-18, 26-31 in decimal; 20-23 reserved. The bank decodes only 0, 1 and 28-31; all others read zero.
// - writing control bit 15 starts soft reset; bit clears itself when done.
// - after soft reset configuration comes from register bits, not mode pins.
// - speed bit picks 100/10, duplex bit full/half; ignored under auto-negotiation.
// - auto-negotiation enable overrides manual speed and duplex.
// - power-down bit enters general power-down; resets to zero.
// - isolate bit cuts the transceiver from the MII; resets to zero.
// - restart bit restarts auto-negotiation and clears itself.
// - collision test bit enables the COL test; resets to zero.
// - status capabilities are constant: no T4, four abilities, aneg and extended.
// - auto-negotiation complete bit mirrors completion; resets to zero.
// - latch-high bits stay set until their register is read.
// - link bit latches low until read, then shows current link.
// - remote fault latches high, cleared by status read.
// - jabber latches high, cleared by status read.
// - event source bits 7..1 hold seven flags; others reserved.
// - mask register holds one mask bit per flag in matching positions.
// - special register gives aneg done, coding enable, speed, scrambler disable.
// - test control register is reserved with no visible function.
// - bits kept across soft reset hold their values through it.
module pmr_bank (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// serial management port
	input wire logic mgmt_clk,
	input wire logic mgmt_data_in,
	output logic mgmt_data_out,
	output logic mgmt_data_oe,
	// straps
	input wire logic [4:0] phy_address,
	input wire logic [2:0] mode_pins,
	// media status
	input wire logic link_up,
	input wire logic remote_fault,
	input wire logic jabber,
	input wire logic aneg_complete,
	input wire logic [2:0] speed_indication,
	input wire logic [7:1] event_pulses,
	// configuration out
	output logic cfg_speed_100,
	output logic cfg_full_duplex,
	output logic cfg_aneg_enable,
	output logic aneg_restart,
	output logic power_down,
	output logic isolate,
	output logic loopback,
	output logic collision_test,
	output logic block_coding_enable,
	output logic scramble_disable,
	output logic soft_reset_active,
	output logic irq_n
);
	logic rst_a;
	logic rst_s;
	logic mdc;
	logic mdio;
	logic mdc_d;
	logic mdc_rise;
	logic mdc_fall;
	logic straps_taken;
	pmr_pkg::pmr_frame_e state;
	logic [5:0] count;
	logic [13:0] head;
	logic is_read;
	logic mine;
	pmr_pkg::pmr_word_t shift;
	logic wr_stb;
	logic rd_stb;
	logic [4:0] rd_reg;
	logic [4:0] wr_reg;
	pmr_pkg::pmr_word_t wr_data;
	logic [15:7] ctl;
	logic [4:0] soft_cnt;
	logic rfault_latch;
	logic jabber_latch;
	logic link_latch;
	logic [7:1] evt;
	logic [7:1] mask;
	logic coding_en;
	logic scr_off;
	logic [4:0] next_reg;
	logic [2:0] settle;

	// register decode; unmapped numbers read zero
	function automatic pmr_pkg::pmr_word_t read_word(input logic [4:0] r);
		pmr_pkg::pmr_word_t w;
		w = 16'h0000;
		case (r)
			`PMR_REG_CONTROL: w = {ctl, 7'h00};
			`PMR_REG_STATUS: begin
				w = `PMR_STS_CAPS;
				w[`PMR_STS_ANEG_DONE] = aneg_complete;
				w[`PMR_STS_RFAULT] = rfault_latch;
				w[`PMR_STS_LINK] = link_latch;
				w[`PMR_STS_JABBER] = jabber_latch;
			end
			`PMR_REG_TEST: w = 16'h0000;
			`PMR_REG_EVENTS: w = {8'h00, evt, 1'b0};
			`PMR_REG_MASK: w = {8'h00, mask, 1'b0};
			`PMR_REG_SPECIAL: begin
				w[`PMR_SPC_ANEG_DONE] = aneg_complete;
				w[`PMR_SPC_CODING] = coding_en;
				w[`PMR_SPC_SPEED_LSB +: 3] = speed_indication;
				w[`PMR_SPC_SCRAMBLE_OFF] = scr_off;
			end
			default: w = 16'h0000;
		endcase
		return w;
	endfunction : read_word

	// reset release
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_a <= 1'b0;
			rst_s <= 1'b0;
		end else begin
			rst_a <= 1'b1;
			rst_s <= rst_a;
		end
	end

	pmr_pin_sync u_mdc (
		.sys_clk(sys_clk),
		.rst_n(rst_s),
		.pin(mgmt_clk),
		.level(mdc)
	);
	pmr_pin_sync u_mdio (
		.sys_clk(sys_clk),
		.rst_n(rst_s),
		.pin(mgmt_data_in),
		.level(mdio)
	);

	// edges ignored until the synchronised clock settles: the swing of the
	// level from its reset value to an idle-high pin is not a clock edge
	always_ff @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s) begin
			mdc_d <= 1'b0;
			settle <= 3'h0;
		end else begin
			mdc_d <= mdc;
			settle <= settle + {2'b00, settle != 3'h7};
		end
	end
	assign mdc_rise = mdc & ~mdc_d & (settle == 3'h7);
	assign mdc_fall = ~mdc & mdc_d & (settle == 3'h7);
	// read strobe on the edge that snapshots the word, so an event that
	// arrives while the data shifts out is never cleared unseen
	assign rd_reg = {head[3:0], mdio};
	assign rd_stb = mdc_rise && state == pmr_pkg::PMR_HEAD && count == 6'd11
		&& head[10:9] == 2'b10 && head[8:4] == phy_address;

	// frame engine: preamble, start, op, addresses, turnaround, data
	always_ff @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s) begin
			state <= pmr_pkg::PMR_IDLE;
			count <= 6'h00;
			head <= 14'h0000;
			is_read <= 1'b0;
			mine <= 1'b0;
			shift <= 16'h0000;
			wr_stb <= 1'b0;
			next_reg <= 5'h00;
			wr_reg <= 5'h00;
			wr_data <= 16'h0000;
		end else begin
			wr_stb <= 1'b0;
			if (mdc_rise) begin
				case (state)
					pmr_pkg::PMR_IDLE: begin
						if (mdio) begin
							count <= (count == 6'h3f) ? count : count + 6'h01;
						end else if (count >= 6'(`PMR_FRAME_PREAMBLE)) begin
							state <= pmr_pkg::PMR_START;
						end else begin
							count <= 6'h00;
						end
					end
					pmr_pkg::PMR_START: begin
						count <= 6'h00;
						state <= mdio ? pmr_pkg::PMR_HEAD : pmr_pkg::PMR_IDLE;
					end
					pmr_pkg::PMR_HEAD: begin
						head <= {head[12:0], mdio};
						count <= count + 6'h01;
						if (count == 6'd11) begin
							is_read <= head[10:9] == 2'b10;
							mine <= head[8:4] == phy_address;
							next_reg <= rd_reg;
							shift <= read_word(rd_reg);
							count <= 6'h00;
							state <= pmr_pkg::PMR_TURN;
						end
					end
					pmr_pkg::PMR_TURN: begin
						count <= count + 6'h01;
						if (count == 6'd1) begin
							count <= 6'h00;
							state <= mine ? pmr_pkg::PMR_DATA : pmr_pkg::PMR_SKIP;
						end
					end
					pmr_pkg::PMR_DATA: begin
						count <= count + 6'h01;
						if (is_read) begin
							shift <= {shift[14:0], 1'b0};
						end else begin
							shift <= {shift[14:0], mdio};
						end
						if (count == 6'd15) begin
							count <= 6'h00;
							state <= pmr_pkg::PMR_IDLE;
							wr_stb <= ~is_read;
							wr_reg <= next_reg;
							wr_data <= {shift[14:0], mdio};
						end
					end
					pmr_pkg::PMR_SKIP: begin
						count <= count + 6'h01;
						if (count == 6'd15) begin
							count <= 6'h00;
							state <= pmr_pkg::PMR_IDLE;
						end
					end
					default: state <= pmr_pkg::PMR_IDLE;
				endcase
			end
		end
	end

	// read data driven from the falling edge so it is stable at the next rise
	always_ff @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s) begin
			mgmt_data_out <= 1'b0;
			mgmt_data_oe <= 1'b0;
		end else if (mdc_fall) begin
			mgmt_data_oe <= mine & is_read & ((state == pmr_pkg::PMR_TURN && count == 6'd1)
				|| state == pmr_pkg::PMR_DATA);
			mgmt_data_out <= (state == pmr_pkg::PMR_DATA) ? shift[15] : 1'b0;
		end else if (state == pmr_pkg::PMR_IDLE) begin
			mgmt_data_oe <= 1'b0;
		end
	end

	// straps caught after reset release
	always_ff @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s) begin
			straps_taken <= 1'b0;
		end else begin
			straps_taken <= 1'b1;
		end
	end

	// basic control; soft reset keeps the speed, aneg and duplex values
	always_ff @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s) begin
			ctl <= 9'h000;
			soft_cnt <= 5'h00;
		end else if (!straps_taken) begin
			ctl[`PMR_CTL_SPEED] <= mode_pins[0];
			ctl[`PMR_CTL_DUPLEX] <= mode_pins[1];
			ctl[`PMR_CTL_ANEG_EN] <= mode_pins[2];
		end else if (soft_cnt != 5'h00) begin
			soft_cnt <= soft_cnt - 5'h01;
			if (soft_cnt == 5'h01) begin
				ctl[`PMR_CTL_RESET] <= 1'b0;
			end
		end else if (wr_stb && wr_reg == `PMR_REG_CONTROL) begin
			if (wr_data[`PMR_CTL_RESET]) begin
				// speed, aneg, duplex held from register, not pins
				ctl[`PMR_CTL_RESET] <= 1'b1;
				ctl[`PMR_CTL_LOOPBACK] <= 1'b0;
				ctl[`PMR_CTL_PWRDN] <= 1'b0;
				ctl[`PMR_CTL_ISOLATE] <= 1'b0;
				ctl[`PMR_CTL_ANEG_RESTART] <= 1'b0;
				ctl[`PMR_CTL_COLTEST] <= 1'b0;
				soft_cnt <= 5'(`PMR_SOFT_RESET_CYC);
			end else begin
				ctl <= wr_data[15:7];
			end
		end else begin
			ctl[`PMR_CTL_ANEG_RESTART] <= 1'b0;
		end
	end

	// latched status; event wins over clear-on-read
	always_ff @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s) begin
			rfault_latch <= 1'b0;
			jabber_latch <= 1'b0;
			link_latch <= 1'b0;
		end else begin
			if (remote_fault) begin
				rfault_latch <= 1'b1;
			end else if (rd_stb && rd_reg == `PMR_REG_STATUS) begin
				rfault_latch <= 1'b0;
			end
			if (jabber) begin
				jabber_latch <= 1'b1;
			end else if (rd_stb && rd_reg == `PMR_REG_STATUS) begin
				jabber_latch <= 1'b0;
			end
			if (!link_up) begin
				link_latch <= 1'b0;
			end else if (rd_stb && rd_reg == `PMR_REG_STATUS) begin
				link_latch <= 1'b1;
			end
		end
	end

	// event flags, mask and special control
	always_ff @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s) begin
			evt <= 7'h00;
			mask <= 7'h00;
			coding_en <= 1'b1;
			scr_off <= 1'b0;
		end else begin
			if (rd_stb && rd_reg == `PMR_REG_EVENTS) begin
				evt <= event_pulses;
			end else begin
				evt <= evt | event_pulses;
			end
			if (wr_stb && wr_reg == `PMR_REG_MASK) begin
				mask <= wr_data[`PMR_EVT_MSB:`PMR_EVT_LSB];
			end
			if (wr_stb && wr_reg == `PMR_REG_SPECIAL) begin
				coding_en <= wr_data[`PMR_SPC_CODING];
				scr_off <= wr_data[`PMR_SPC_SCRAMBLE_OFF];
			end
		end
	end

	assign cfg_aneg_enable = ctl[`PMR_CTL_ANEG_EN];
	assign cfg_speed_100 = ctl[`PMR_CTL_SPEED];
	assign cfg_full_duplex = ctl[`PMR_CTL_DUPLEX];
	assign aneg_restart = ctl[`PMR_CTL_ANEG_RESTART];
	assign power_down = ctl[`PMR_CTL_PWRDN];
	assign isolate = ctl[`PMR_CTL_ISOLATE];
	assign loopback = ctl[`PMR_CTL_LOOPBACK];
	assign collision_test = ctl[`PMR_CTL_COLTEST];
	assign soft_reset_active = ctl[`PMR_CTL_RESET];
	assign block_coding_enable = coding_en;
	assign scramble_disable = scr_off;
	assign irq_n = ~|(evt & mask);
endmodule : pmr_bank

//--- pmr_bank_asserts.sv
// port checker for the management register bank
// assumes sys_clk only domain; bound to every pmr_bank
module pmr_bank_chk (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// watched ports
	input wire logic mgmt_clk,
	input wire logic mgmt_data_oe,
	input wire logic cfg_speed_100,
	input wire logic cfg_full_duplex,
	input wire logic cfg_aneg_enable,
	input wire logic aneg_restart,
	input wire logic power_down,
	input wire logic isolate,
	input wire logic loopback,
	input wire logic collision_test,
	input wire logic block_coding_enable,
	input wire logic soft_reset_active,
	input wire logic irq_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic mc_q;
	logic [7:0] idle;
	// cycles since the link clock last moved
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mc_q <= 1'b0;
			idle <= 8'h00;
		end else begin
			mc_q <= mgmt_clk;
			idle <= (mgmt_clk != mc_q) ? 8'h00 : idle + {7'h00, idle != 8'hff};
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_rst;
		$rose(rst_n) |-> !power_down && !isolate && !collision_test && block_coding_enable;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset values");
	property p_sr_len;
		$rose(soft_reset_active) |-> soft_reset_active[*8] ##[1:25] !soft_reset_active;
	endproperty
	a_sr_len: assert property (p_sr_len) else $error("soft reset length");
	property p_sr_keep;
		soft_reset_active && $past(soft_reset_active)
			|-> $stable({cfg_speed_100, cfg_aneg_enable, cfg_full_duplex});
	endproperty
	a_sr_keep: assert property (p_sr_keep) else $error("kept bits moved");
	property p_sr_clr;
		$fell(soft_reset_active) |-> !power_down && !isolate && !collision_test;
	endproperty
	a_sr_clr: assert property (p_sr_clr) else $error("soft reset left bits");
	property p_rs_pulse;
		$rose(aneg_restart) |-> idle < 8'd20 ##[1:3] !aneg_restart;
	endproperty
	a_rs_pulse: assert property (p_rs_pulse) else $error("restart pulse");
	property p_oe_idle;
		idle > 8'd40 |-> !mgmt_data_oe;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("drive while idle");
	property p_irq_hold;
		idle > 8'd40 && !irq_n |=> !irq_n;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq withdrawn");
	property p_cfg_cause;
		$changed({power_down, isolate, collision_test, loopback}) |-> idle < 8'd40;
	endproperty
	a_cfg_cause: assert property (p_cfg_cause) else $error("cfg moved alone");
endmodule : pmr_bank_chk
bind pmr_bank pmr_bank_chk pmr_bank_chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
	.mgmt_clk(mgmt_clk), .mgmt_data_oe(mgmt_data_oe), .cfg_speed_100(cfg_speed_100),
	.cfg_full_duplex(cfg_full_duplex), .cfg_aneg_enable(cfg_aneg_enable),
	.aneg_restart(aneg_restart), .power_down(power_down), .isolate(isolate),
	.loopback(loopback), .collision_test(collision_test),
	.block_coding_enable(block_coding_enable), .soft_reset_active(soft_reset_active),
	.irq_n(irq_n));

//--- pmr_consts.svh
// register numbers, field positions, reset values and timing counts
// assumes inclusion by bare name from the register bank design file
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH
`define PMR_REG_CONTROL 5'h00
`define PMR_REG_STATUS 5'h01
`define PMR_REG_ID1 5'h02
`define PMR_REG_ID2 5'h03
`define PMR_REG_ADV 5'h04
`define PMR_REG_PARTNER 5'h05
`define PMR_REG_EXPANSION 5'h06
`define PMR_REG_TEST 5'h1c
`define PMR_REG_EVENTS 5'h1d
`define PMR_REG_MASK 5'h1e
`define PMR_REG_SPECIAL 5'h1f
`define PMR_CTL_RESET 15
`define PMR_CTL_LOOPBACK 14
`define PMR_CTL_SPEED 13
`define PMR_CTL_ANEG_EN 12
`define PMR_CTL_PWRDN 11
`define PMR_CTL_ISOLATE 10
`define PMR_CTL_ANEG_RESTART 9
`define PMR_CTL_DUPLEX 8
`define PMR_CTL_COLTEST 7
`define PMR_STS_CAPS 16'h7809
`define PMR_STS_ANEG_DONE 5
`define PMR_STS_RFAULT 4
`define PMR_STS_LINK 2
`define PMR_STS_JABBER 1
`define PMR_EVT_LSB 1
`define PMR_EVT_MSB 7
`define PMR_SPC_ANEG_DONE 12
`define PMR_SPC_CODING 6
`define PMR_SPC_SPEED_LSB 2
`define PMR_SPC_SCRAMBLE_OFF 0
`define PMR_SOFT_RESET_NS 1000
`define PMR_CLK_NS 50
`define PMR_SOFT_RESET_CYC ((`PMR_SOFT_RESET_NS + `PMR_CLK_NS - 1) / `PMR_CLK_NS)
`define PMR_FRAME_PREAMBLE 32
`endif

//--- pmr_mgmt_model.sv
// management controller model sending serial management frames
// assumes tasks are entered just after a sys_clk edge; 8 cycles per bit
module pmr_mgmt_model (
	// clock
	input wire logic sys_clk,
	// link pins
	input wire logic wire_in,
	output logic mgmt_clk,
	output logic drv_bit,
	output logic drv_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		mgmt_clk = 1'b1;
		drv_bit = 1'b1;
		drv_oe = 1'b0;
	end
	// sample late in the high phase: the device answers slowly through its sync
	task automatic bit_cycle(input logic oe, input logic b, output logic r);
		mgmt_clk <= 1'b0;
		drv_oe <= oe;
		drv_bit <= b;
		repeat (4) @(posedge sys_clk);
		mgmt_clk <= 1'b1;
		repeat (4) @(posedge sys_clk);
		r = wire_in;
	endtask : bit_cycle
	task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] rg,
		input logic [15:0] wd, output logic [15:0] q);
		logic [31:0] head;
		logic r;
		head = {2'b01, rd ? 2'b10 : 2'b01, phy, rg, 2'b10, wd};
		for (int i = 0; i < 64; i++) begin
			bit_cycle(!(rd && i >= 46), i < 32 ? 1'b1 : head[63 - i], r);
			if (i >= 48)
				q = {q[14:0], r};
		end
		drv_oe <= 1'b0;
	endtask : frame
endmodule : pmr_mgmt_model

//--- pmr_pin_sync.sv
// three-stage synchroniser with agreement filter for one pin
// assumes sys_clk domain; output changes when stages two and three agree
module pmr_pin_sync (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// pin in, clean level out
	input wire logic pin,
	output logic level
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= 1'b0;
		end else if (s2 == s3) begin
			level <= s3;
		end
	end
endmodule : pmr_pin_sync

//--- pmr_pkg.sv
// types shared by the management register bank
// assumes pmr_consts.svh is available on the include path
package pmr_pkg;
	typedef enum logic [2:0] {
		PMR_IDLE = 3'b000,
		PMR_START = 3'b001,
		PMR_HEAD = 3'b010,
		PMR_TURN = 3'b011,
		PMR_DATA = 3'b100,
		PMR_SKIP = 3'b101
	} pmr_frame_e;
	typedef logic [15:0] pmr_word_t;
endpackage : pmr_pkg
